// file: core/mflint_pkg.sv
// Contract
// - Bytes 4-7 hold per-lane summaries, bit7=lane8.
// - Summary bit set while any lane flag set.
// - Summary reads never clear underlying lane flags.
// - Every module-level flag has its own mask.
// - Separate high/low alarm and warning flags, masked.
// - All module flags zero after reset, idle.
// - Latched flag holds until read or reset.
// - Unmasked flag onset asserts the interrupt.
// - Interrupt holds until all flags read clear; code releases once no unmasked flag is left pending.
// - Persisting condition sets flag again after read.
// - Byte 13 holds vendor module-level flags.
// - Byte 8 bits 7/6 latch command completions.
// - Byte 8 bit 2 datapath firmware fault.
// - Byte 8 bit 1 module firmware fault.
// - Byte 8 bit 0 latches module state change.
// - Byte 9 supply then temperature thresholds.
// - Byte 10 aux2 then aux1 thresholds.
// - Some flags suppressed in disallowed module states.
// - Byte 3 bit 0 mirrors interrupt, 0=asserted.
// - Byte 3 bits 3-1 report module state.
`default_nettype none
package mflint_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Byte offsets on the lower page
  localparam logic [7:0] STATUS_OFF = 8'h03;
  localparam logic [7:0] BANK0_LANE_SUMMARY_OFF = 8'h04;
  localparam logic [7:0] BANK1_LANE_SUMMARY_OFF = 8'h05;
  localparam logic [7:0] BANK2_LANE_SUMMARY_OFF = 8'h06;
  localparam logic [7:0] BANK3_LANE_SUMMARY_OFF = 8'h07;
  localparam logic [7:0] MODULE_EVENT_FLAGS_OFF = 8'h08;
  localparam logic [7:0] SUPPLY_TEMP_THRESHOLD_FLAGS_OFF = 8'h09;
  localparam logic [7:0] AUX_MONITOR_THRESHOLD_FLAGS_OFF = 8'h0a;
  localparam logic [7:0] CUSTOM_MODULE_FLAGS_OFF = 8'h0d;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CMD_BLOCK2_DONE_BIT = 7;
  localparam int CMD_BLOCK1_DONE_BIT = 6;
  localparam int DP_FW_FAULT_BIT = 2;
  localparam int MOD_FW_FAULT_BIT = 1;
  localparam int STATE_CHANGED_BIT = 0;
  localparam logic [7:0] EVENT_USED_BITS = 8'hc7;
  localparam int HI_NIBBLE_LSB = 4;
  localparam int LO_NIBBLE_LSB = 0;
  localparam int STATE_FIELD_LSB = 1;
  localparam int INT_STATUS_BIT = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [2:0] MODULE_STATE_RESET = 3'h0;
  localparam logic INT_N_RESET = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Module state codes
  localparam logic [2:0] ST_LOW_PWR = 3'h1;
  localparam logic [2:0] ST_PWR_UP = 3'h2;
  localparam logic [2:0] ST_READY = 3'h3;
  localparam logic [2:0] ST_PWR_DN = 3'h4;
  localparam logic [2:0] ST_FAULT = 3'h5;

  // Interrupt pin states
  typedef enum logic [1:0] {
    INT_IDLE = 2'b01,
    INT_ACTIVE = 2'b10
  } mflint_int_state_type;

endpackage
`default_nettype wire

// file: core/mflint_flag_latch.sv
`timescale 1ns/1ps
`default_nettype none
module mflint_flag_latch #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Condition and clear
  input wire logic [WIDTH-1:0] set_in,
  input wire logic [WIDTH-1:0] clr_in,
  // Latched flags
  output logic [WIDTH-1:0] flag_out
);

  logic [WIDTH-1:0] flag_q;
  logic [WIDTH-1:0] flag_d;

  if (WIDTH < 1) begin : g_bad_width
    $error("mflint_flag_latch: WIDTH must be at least 1");
  end

  // Set beats clear; a held condition sets again after the read
  always_comb begin
    flag_d = set_in | (flag_q & ~clr_in);
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      flag_q <= '0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign flag_out = flag_q;

endmodule
`default_nettype wire

// file: core/mflint_flag_block.sv
`timescale 1ns/1ps
`default_nettype none
module mflint_flag_block #(
  parameter int NUM_BANKS = 4,
  parameter int LANES_PER_BANK = 8
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Byte read port from the management bus slave
  input wire logic rd_strobe_in,
  input wire logic [7:0] rd_addr_in,
  output logic [7:0] rd_data_out,
  output logic rd_valid_out,
  // Lane flag page status
  input wire logic [NUM_BANKS*LANES_PER_BANK-1:0] lane_flag_any_in,
  input wire logic lane_int_pend_in,
  // Module state machine
  input wire logic [2:0] module_state_in,
  // Byte 8 conditions
  input wire logic cmd_block2_done_in,
  input wire logic cmd_block1_done_in,
  input wire logic dp_fw_fault_in,
  input wire logic mod_fw_fault_in,
  // Threshold conditions {low warn, high warn, low alarm, high alarm}
  input wire logic [3:0] main_supply_monitor_cond_in,
  input wire logic [3:0] temp_cond_in,
  input wire logic [3:0] aux2_cond_in,
  input wire logic [3:0] aux1_cond_in,
  // Vendor conditions
  input wire logic [7:0] custom_cond_in,
  // Masks, one bit per flag, 1 masks
  input wire logic [7:0] event_mask_in,
  input wire logic [7:0] supply_temp_mask_in,
  input wire logic [7:0] aux_mask_in,
  input wire logic [7:0] custom_mask_in,
  // Interrupt pin, active low
  output logic int_n_out
);

  localparam int NUM_LANES = NUM_BANKS * LANES_PER_BANK;

  // Elaboration checks
  if (NUM_BANKS < 1 || NUM_BANKS > 4) begin : g_bad_banks
    $error("mflint_flag_block: NUM_BANKS must be 1 to 4");
  end
  if (LANES_PER_BANK != 8) begin : g_bad_lanes
    $error("mflint_flag_block: LANES_PER_BANK must be 8");
  end
  // Reserved bits 5-3 of the event byte must never latch
  if ((mflint_pkg::EVENT_USED_BITS & 8'h38) != 8'h00) begin : g_bad_event_bits
    $error("mflint_flag_block: event byte bits 5-3 are reserved");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] off);
    addr_hit = (addr == off);
  endfunction

  function automatic logic any_unmasked(input logic [7:0] flags, input logic [7:0] mask);
    any_unmasked = |(flags & ~mask);
  endfunction

  // Threshold flags only meaningful once the module is powered
  function automatic logic thresholds_allowed(input logic [2:0] state);
    thresholds_allowed = (state == mflint_pkg::ST_READY) ||
      (state == mflint_pkg::ST_PWR_DN);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Lane flag summary

  logic [NUM_LANES-1:0] summary_q;
  logic [7:0] summary_byte [0:3];

  // Level copy; reading it has no effect on the lane flags
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      summary_q <= '0;
    end else begin
      summary_q <= lane_flag_any_in;
    end
  end

  // Banks past NUM_BANKS read as zero
  for (genvar b = 0; b < 4; b++) begin : g_bank
    if (b < NUM_BANKS) begin : g_used
      assign summary_byte[b] = summary_q[b*LANES_PER_BANK +: LANES_PER_BANK];
    end else begin : g_unused
      assign summary_byte[b] = 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reported module state and change detection

  logic [2:0] state_q;
  logic state_seen_q;
  logic state_change;

  // Reported state lags the input by one cycle
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_q <= mflint_pkg::MODULE_STATE_RESET;
    end else begin
      state_q <= module_state_in;
    end
  end

  // Marks the first clean sample after reset
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_seen_q <= 1'b0;
    end else begin
      state_seen_q <= 1'b1;
    end
  end

  // First sample after reset is not a change
  assign state_change = state_seen_q && (module_state_in != state_q);

  ////////////////////////////////////////////////////////////////////////////
  // Clear-on-read strobes

  logic clr_event;
  logic clr_supply_temp;
  logic clr_aux;
  logic clr_custom;

  // Summary bytes and byte 3 have no read side effect
  assign clr_event = rd_strobe_in && addr_hit(rd_addr_in, mflint_pkg::MODULE_EVENT_FLAGS_OFF);
  assign clr_supply_temp = rd_strobe_in &&
    addr_hit(rd_addr_in, mflint_pkg::SUPPLY_TEMP_THRESHOLD_FLAGS_OFF);
  assign clr_aux = rd_strobe_in &&
    addr_hit(rd_addr_in, mflint_pkg::AUX_MONITOR_THRESHOLD_FLAGS_OFF);
  assign clr_custom = rd_strobe_in && addr_hit(rd_addr_in, mflint_pkg::CUSTOM_MODULE_FLAGS_OFF);

  ////////////////////////////////////////////////////////////////////////////
  // Flag conditions

  logic [7:0] event_set;
  logic [7:0] supply_temp_set;
  logic [7:0] aux_set;
  logic thr_ok;

  assign thr_ok = thresholds_allowed(module_state_in);

  // Bits 5-3 stay zero
  always_comb begin
    event_set = 8'h00;
    event_set[mflint_pkg::CMD_BLOCK2_DONE_BIT] = cmd_block2_done_in;
    event_set[mflint_pkg::CMD_BLOCK1_DONE_BIT] = cmd_block1_done_in;
    event_set[mflint_pkg::DP_FW_FAULT_BIT] = dp_fw_fault_in && thr_ok;
    event_set[mflint_pkg::MOD_FW_FAULT_BIT] = mod_fw_fault_in;
    event_set[mflint_pkg::STATE_CHANGED_BIT] = state_change;
  end

  // Conditions outside the allowed states are dropped, latched flags stay
  always_comb begin
    supply_temp_set = 8'h00;
    if (thr_ok) begin
      supply_temp_set[mflint_pkg::HI_NIBBLE_LSB +: 4] = main_supply_monitor_cond_in;
      supply_temp_set[mflint_pkg::LO_NIBBLE_LSB +: 4] = temp_cond_in;
    end
  end

  always_comb begin
    aux_set = 8'h00;
    if (thr_ok) begin
      aux_set[mflint_pkg::HI_NIBBLE_LSB +: 4] = aux2_cond_in;
      aux_set[mflint_pkg::LO_NIBBLE_LSB +: 4] = aux1_cond_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Latched flag bytes

  logic [7:0] event_flags;
  logic [7:0] supply_temp_flags;
  logic [7:0] aux_flags;
  logic [7:0] custom_flags;

  // Only bits the read returns are cleared
  mflint_flag_latch #(
    .WIDTH(8)
  ) u_event_flags (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .set_in(event_set & mflint_pkg::EVENT_USED_BITS),
    .clr_in({8{clr_event}} & event_flags),
    .flag_out(event_flags)
  );

  mflint_flag_latch #(
    .WIDTH(8)
  ) u_supply_temp_flags (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .set_in(supply_temp_set),
    .clr_in({8{clr_supply_temp}} & supply_temp_flags),
    .flag_out(supply_temp_flags)
  );

  mflint_flag_latch #(
    .WIDTH(8)
  ) u_aux_flags (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .set_in(aux_set),
    .clr_in({8{clr_aux}} & aux_flags),
    .flag_out(aux_flags)
  );

  mflint_flag_latch #(
    .WIDTH(8)
  ) u_custom_flags (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .set_in(custom_cond_in),
    .clr_in({8{clr_custom}} & custom_flags),
    .flag_out(custom_flags)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt

  mflint_pkg::mflint_int_state_type int_state_q;
  mflint_pkg::mflint_int_state_type int_state_d;
  logic [3:0] byte_pending;
  logic int_pending;

  // Each flag gated by its own mask bit
  assign byte_pending[0] = any_unmasked(event_flags, event_mask_in);
  assign byte_pending[1] = any_unmasked(supply_temp_flags, supply_temp_mask_in);
  assign byte_pending[2] = any_unmasked(aux_flags, aux_mask_in);
  assign byte_pending[3] = any_unmasked(custom_flags, custom_mask_in);

  // Lane flags are masked and cleared on the lane page itself
  assign int_pending = (|byte_pending) || lane_int_pend_in;

  // Release only once nothing unmasked is left pending
  always_comb begin
    case (int_state_q)
      mflint_pkg::INT_IDLE: begin
        int_state_d = int_pending ? mflint_pkg::INT_ACTIVE : mflint_pkg::INT_IDLE;
      end
      mflint_pkg::INT_ACTIVE: begin
        int_state_d = int_pending ? mflint_pkg::INT_ACTIVE : mflint_pkg::INT_IDLE;
      end
      default: begin
        int_state_d = mflint_pkg::INT_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      int_state_q <= mflint_pkg::INT_IDLE;
    end else begin
      int_state_q <= int_state_d;
    end
  end

  // Registered so reads never glitch the pin
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      int_n_out <= mflint_pkg::INT_N_RESET;
    end else begin
      int_n_out <= (int_state_d != mflint_pkg::INT_ACTIVE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  logic [7:0] status_byte;
  logic [7:0] rd_mux;

  always_comb begin
    status_byte = 8'h00;
    status_byte[mflint_pkg::STATE_FIELD_LSB +: 3] = state_q;
    status_byte[mflint_pkg::INT_STATUS_BIT] = int_n_out;
  end

  always_comb begin
    case (rd_addr_in)
      mflint_pkg::STATUS_OFF: begin
        rd_mux = status_byte;
      end
      mflint_pkg::BANK0_LANE_SUMMARY_OFF: begin
        rd_mux = summary_byte[0];
      end
      mflint_pkg::BANK1_LANE_SUMMARY_OFF: begin
        rd_mux = summary_byte[1];
      end
      mflint_pkg::BANK2_LANE_SUMMARY_OFF: begin
        rd_mux = summary_byte[2];
      end
      mflint_pkg::BANK3_LANE_SUMMARY_OFF: begin
        rd_mux = summary_byte[3];
      end
      mflint_pkg::MODULE_EVENT_FLAGS_OFF: begin
        rd_mux = event_flags;
      end
      mflint_pkg::SUPPLY_TEMP_THRESHOLD_FLAGS_OFF: begin
        rd_mux = supply_temp_flags;
      end
      mflint_pkg::AUX_MONITOR_THRESHOLD_FLAGS_OFF: begin
        rd_mux = aux_flags;
      end
      mflint_pkg::CUSTOM_MODULE_FLAGS_OFF: begin
        rd_mux = custom_flags;
      end
      // Unmapped and reserved bytes read zero
      default: begin
        rd_mux = 8'h00;
      end
    endcase
  end

  // Holds the last answer until the next strobe
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rd_data_out <= mflint_pkg::FLAGS_RESET;
    end else if (rd_strobe_in) begin
      rd_data_out <= rd_mux;
    end
  end

  // Answer valid flag follows the strobe one cycle later, one cycle per strobe cycle
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rd_valid_out <= 1'b0;
    end else begin
      rd_valid_out <= rd_strobe_in;
    end
  end

endmodule
`default_nettype wire

// file: verif/mflint_flag_chk.sv
`timescale 1ns/1ps
`default_nettype none
module mflint_flag_chk #(
  parameter int NUM_BANKS = 4,
  parameter int LANES_PER_BANK = 8
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Read port
  input wire logic rd_strobe_in,
  input wire logic [7:0] rd_addr_in,
  input wire logic [7:0] rd_data_out,
  input wire logic rd_valid_out,
  // Conditions and masks
  input wire logic [NUM_BANKS*LANES_PER_BANK-1:0] lane_flag_any_in,
  input wire logic lane_int_pend_in,
  input wire logic [2:0] module_state_in,
  input wire logic [7:0] custom_cond_in,
  input wire logic [7:0] custom_mask_in,
  input wire logic [7:0] event_mask_in,
  // Interrupt pin
  input wire logic int_n_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);
  ////////////////////////////////////////////////////////////////////////////
  reset_idle_a: assert property (
    $fell(sys_rst_in) |-> int_n_out && !rd_valid_out && rd_data_out == 8'h00)
    else $error("outputs not idle after reset");
  summary_read_a: assert property (
    rd_strobe_in && rd_addr_in == 8'h04 && $stable(lane_flag_any_in[7:0])
    |=> rd_data_out == $past(lane_flag_any_in[7:0])) else $error("bank 0 summary wrong");
  event_resv_a: assert property (
    rd_strobe_in && rd_addr_in == 8'h08 |=> rd_data_out[5:3] == 3'h0)
    else $error("byte 8 reserved bits set");
  status_byte_a: assert property (
    rd_strobe_in && rd_addr_in == 8'h03
    |=> rd_data_out[0] == $past(int_n_out) && rd_data_out[7:4] == 4'h0)
    else $error("status byte pin mirror wrong");
  int_onset_a: assert property (
    $rose(custom_cond_in[0]) && !custom_mask_in[0] |=> ##1 !int_n_out)
    else $error("pin not asserted at onset");
  int_hold_a: assert property (
    !int_n_out && !rd_strobe_in && !$past(rd_strobe_in) && lane_int_pend_in
    && $past(lane_int_pend_in) |=> !int_n_out) else $error("pin released without read");
  lane_pend_a: assert property (
    lane_int_pend_in [*2] |=> !int_n_out) else $error("lane pending not on pin");
  state_chg_a: assert property (
    $changed(module_state_in) && !$past(sys_rst_in) && !event_mask_in[0]
    |-> ##[1:3] !int_n_out) else $error("state change not signalled");
  persist_a: assert property (
    (rd_strobe_in && rd_addr_in == 8'h0d && custom_cond_in[0]) [*2] |=> rd_data_out[0])
    else $error("persisting flag lost");
  cover property (rd_valid_out && rd_data_out != 8'h00);
  cover property ($fell(int_n_out));
  cover property ($rose(int_n_out));
endmodule
`default_nettype wire

// file: verif/mflint_host.sv
`timescale 1ns/1ps
`default_nettype none
module mflint_host (
  // Clock
  input wire logic clk_in,
  // Read request
  output logic rd_strobe_out,
  output logic [7:0] rd_addr_out,
  // Read answer
  input wire logic [7:0] rd_data_in,
  input wire logic rd_valid_in
);
  initial begin
    rd_strobe_out = 1'b0;
    rd_addr_out = 8'h00;
  end
  // Strobe held n edges, answer of the last one returned
  task automatic rd(input logic [7:0] a, input int n, output logic [7:0] d);
    rd_strobe_out <= 1'b1;
    rd_addr_out <= a;
    repeat (n) @(posedge clk_in);
    rd_strobe_out <= 1'b0;
    rd_addr_out <= ~a;
    #1;
    d = rd_valid_in ? rd_data_in : 8'hxx;
    @(posedge clk_in);
  endtask
endmodule
`default_nettype wire

// file: verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic pend = 1'b0, c2 = 1'b0, c1 = 1'b0, dpf = 1'b0, mfw = 1'b0;
  logic [31:0] lane = 32'h0;
  logic [2:0] st = mflint_pkg::ST_LOW_PWR;
  logic [3:0] sup = 4'h0, tmp = 4'h0, ax2 = 4'h0, ax1 = 4'h0;
  logic [7:0] cust = 8'h0, emask = 8'h0, smask = 8'h0, amask = 8'h0, cmask = 8'h0;
  logic strobe, valid, int_n;
  logic [7:0] addr, data;
  logic [7:0] fa [4] = '{8'h08, 8'h09, 8'h0a, 8'h0d};
  localparam logic [31:0] LV = 32'h8011_2201;
  int mismatches = 0;
  int n_tests = 0;
  int cyc = 0;
  always #10 clk_in = ~clk_in;
  mflint_flag_block u_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .rd_strobe_in(strobe),
    .rd_addr_in(addr), .rd_data_out(data), .rd_valid_out(valid), .lane_flag_any_in(lane),
    .lane_int_pend_in(pend), .module_state_in(st), .cmd_block2_done_in(c2),
    .cmd_block1_done_in(c1), .dp_fw_fault_in(dpf), .mod_fw_fault_in(mfw),
    .main_supply_monitor_cond_in(sup), .temp_cond_in(tmp), .aux2_cond_in(ax2),
    .aux1_cond_in(ax1), .custom_cond_in(cust), .event_mask_in(emask),
    .supply_temp_mask_in(smask), .aux_mask_in(amask), .custom_mask_in(cmask),
    .int_n_out(int_n));
  mflint_host u_host (.clk_in(clk_in), .rd_strobe_out(strobe), .rd_addr_out(addr),
    .rd_data_in(data), .rd_valid_in(valid));
  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (mismatches == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic rc(input logic [7:0] a, input int n, input logic [7:0] e);
    logic [7:0] d;
    u_host.rd(a, n, d);
    chk(d, e);
  endtask
  task automatic pin(input logic e);
    #1;
    chk({7'h00, int_n}, {7'h00, e});
    @(posedge clk_in);
  endtask
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    tick(12);
    sys_rst_in <= 1'b0;
    tick(2);
    rc(8'h03, 1, {4'h0, mflint_pkg::ST_LOW_PWR, 1'b1});
    foreach (fa[i]) rc(fa[i], 1, 8'h00);
    rc(8'h0b, 1, 8'h00);
    lane <= LV;
    tick(2);
    for (int r = 0; r < 2; r++)
      for (int b = 0; b < 4; b++) rc(8'h04 + 8'(b), 1, LV[8*b +: 8]);
    pend <= 1'b1;
    tick(2);
    pin(1'b0);
    pend <= 1'b0;
    lane <= 32'h0;
    tick(2);
    pin(1'b1);
    tmp <= 4'h1;
    dpf <= 1'b1;
    tick(2);
    tmp <= 4'h0;
    dpf <= 1'b0;
    rc(8'h09, 1, 8'h00);
    rc(8'h08, 1, 8'h00);
    st <= mflint_pkg::ST_READY;
    tick(3);
    pin(1'b0);
    rc(8'h08, 1, 8'h01);
    tick(1);
    pin(1'b1);
    {c2, c1, dpf, mfw} <= 4'hf;
    {sup, tmp, ax2, ax1} <= 16'h8124;
    tick(1);
    {c2, c1, dpf, mfw} <= 4'h0;
    {sup, tmp, ax2, ax1} <= 16'h0;
    tick(2);
    rc(8'h08, 1, 8'hc6);
    rc(8'h09, 1, 8'h81);
    rc(8'h0a, 1, 8'h24);
    rc(8'h08, 1, 8'h00);
    smask <= 8'hff;
    tmp <= 4'h2;
    tick(1);
    tmp <= 4'h0;
    tick(2);
    pin(1'b1);
    rc(8'h09, 1, 8'h02);
    smask <= 8'h00;
    cust <= 8'h01;
    tick(3);
    pin(1'b0);
    rc(8'h0d, 2, 8'h01);
    pin(1'b0);
    cust <= 8'h00;
    tick(1);
    rc(8'h0d, 1, 8'h01);
    rc(8'h0d, 1, 8'h00);
    tick(1);
    pin(1'b1);
    {emask, amask, cmask} <= 24'h01_80_01;
    st <= mflint_pkg::ST_PWR_DN;
    {ax2, cust} <= {4'h8, 8'h01};
    tick(1);
    {ax2, cust} <= 12'h000;
    tick(2);
    pin(1'b1);
    rc(8'h08, 1, 8'h01);
    rc(8'h0a, 1, 8'h80);
    rc(8'h0d, 1, 8'h01);
    {emask, amask, cmask} <= 24'h00_0000;
    cust <= 8'h80;
    tick(1);
    cust <= 8'h00;
    tick(1);
    sys_rst_in <= 1'b1;
    tick(2);
    sys_rst_in <= 1'b0;
    tick(2);
    rc(8'h0d, 1, 8'h00);
    pin(1'b1);
    summarize();
  end
endmodule
bind mflint_flag_block mflint_flag_chk #(.NUM_BANKS(NUM_BANKS),
  .LANES_PER_BANK(LANES_PER_BANK)) u_chk (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
  .rd_strobe_in(rd_strobe_in), .rd_addr_in(rd_addr_in), .rd_data_out(rd_data_out),
  .rd_valid_out(rd_valid_out), .lane_flag_any_in(lane_flag_any_in),
  .lane_int_pend_in(lane_int_pend_in), .module_state_in(module_state_in),
  .custom_cond_in(custom_cond_in), .custom_mask_in(custom_mask_in),
  .event_mask_in(event_mask_in), .int_n_out(int_n_out));
`default_nettype wire
